// ### src/qsf_pkg.sv
// Types shared by the serial flash master and its bench.
// Assumes the register header is included alongside.
package qsf_pkg;
  // Frame phases
  typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_ADDR, PH_MODE, PH_DUMMY,
    PH_DATA} phase_t;
  // Pin group toward the flash; bit n of a vector is serial_io_n
  typedef struct packed {
    logic serial_clock;
    logic slave_select_n;
    logic [3:0] serial_io_o;
    logic [3:0] serial_io_oe;
  } pins_out_t;
  // Queue and DMA conditions
  typedef struct packed {
    logic tx_queue_empty_flag;
    logic tx_queue_full_flag;
    logic tx_queue_overflow_flag;
    logic rx_queue_empty_flag;
    logic rx_queue_full_flag;
    logic rx_queue_underflow_flag;
    logic tx_dma_req;
    logic rx_dma_req;
  } events_t;
endpackage

// ### src/qsf_regs.svh
// Register map, field positions, reset values and timing counts of the
// serial flash master. Assumes a 32-bit APB slave with word offsets.
`ifndef QSF_REGS_SVH
`define QSF_REGS_SVH
// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define QSF_CONF 12'h000
`define QSF_OPCODE 12'h004
`define QSF_LOCATION 12'h008
`define QSF_READ_MODE 12'h00c
`define QSF_HEADER 12'h010
`define QSF_RXCOUNT 12'h014
`define QSF_TXDATA 12'h018
`define QSF_RXDATA 12'h01c
`define QSF_STATUS 12'h020
`define QSF_SECOND_CONF 12'h024
// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define QSF_C_LANES 0
`define QSF_C_ALANE 2
`define QSF_C_WRITE 3
`define QSF_C_PACK 4
`define QSF_C_START 5
`define QSF_C_STOP 6
`define QSF_H_CMD 0
`define QSF_H_ADDR 2
`define QSF_H_RM 5
`define QSF_H_DUMMY 7
`define QSF_S_TXE 0
`define QSF_S_TXF 1
`define QSF_S_TXO 2
`define QSF_S_RXE 3
`define QSF_S_RXF 4
`define QSF_S_RXU 5
`define QSF_S_BUSY 6
`define QSF_D_TX 0
`define QSF_D_RX 1
// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define QSF_RST_HDR 9'h000
`define QSF_RST_RXCNT 16'h0000
`define QSF_SCK_HALF 4
`endif

// ### src/quad_serial_flash_master.sv
// Single, dual and quad serial flash master with APB registers and
// 8 by 32 transmit and receive queues.
// Assumes pins are resolved outside; serial inputs are asynchronous.
`timescale 1ns/1ns
`include "qsf_regs.svh"
module quad_serial_flash_master
  import qsf_pkg::*;
#(
  parameter int SCK_HALF = `QSF_SCK_HALF,
  parameter int DEPTH = 8
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic [3:0] serial_io_i,
  output pins_out_t pins,
  // Queue conditions and DMA requests
  output events_t events
);
  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    phase_t ph;
    logic [2:0] left;
    logic [7:0] sh;
    logic [3:0] nb;
    logic [2:0] lanes;
    logic rxb;
    logic [7:0] div;
    logic sck;
    logic ss_n;
    logic [3:0] io_o;
    logic [3:0] io_oe;
    logic [15:0] rcnt;
    logic [1:0] bsel;
    logic [31:0] acc;
    logic [1:0] dl;
    logic al;
    logic wr;
    logic pack;
    logic stop;
    logic [15:0] op;
    logic [31:0] loc;
    logic [15:0] rm;
    logic [8:0] hdr;
    logic [15:0] rxcnt;
    logic [1:0] dma;
    logic [DEPTH-1:0][31:0] txm;
    logic [AW-1:0] twp;
    logic [AW-1:0] trp;
    logic [AW:0] tcnt;
    logic [DEPTH-1:0][31:0] rxm;
    logic [AW-1:0] rwp;
    logic [AW-1:0] rrp;
    logic [AW:0] rcn;
    logic tovf;
    logic rudf;
    logic [31:0] rdata;
    logic [3:0] s1;
    logic [3:0] s2;
  } state_t;

  state_t s;
  state_t next_s;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Lanes per clock from a lane code; the reserved code falls back to one
  function automatic logic [2:0] lane_bits(input logic [1:0] code);
    case (code)
      2'b01: lane_bits = 3'd2;
      2'b10: lane_bits = 3'd4;
      default: lane_bits = 3'd1;
    endcase
  endfunction

  // Picks byte k-1 of a word, so a count walks high byte first
  function automatic logic [7:0] pick(input logic [31:0] w,
    input logic [2:0] k);
    case (k)
      3'd4: pick = w[31:24];
      3'd3: pick = w[23:16];
      3'd2: pick = w[15:8];
      default: pick = w[7:0];
    endcase
  endfunction

  // Register the serial inputs twice before anything looks at them
  logic [3:0] io_sync;
  assign io_sync = s.s2;

  logic apb_wr;
  logic apb_rd;
  logic apb_setup;
  logic mapped;
  logic tfull;
  logic tempty;
  logic rfull;
  logic rempty;
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign tfull = (s.tcnt == DEPTH[AW:0]);
  assign tempty = (s.tcnt == '0);
  assign rfull = (s.rcn == DEPTH[AW:0]);
  assign rempty = (s.rcn == '0);

  // Every word offset up to config two is mapped
  always_comb
  begin
    case (paddr)
      `QSF_CONF, `QSF_OPCODE, `QSF_LOCATION, `QSF_READ_MODE, `QSF_HEADER,
      `QSF_RXCOUNT, `QSF_TXDATA, `QSF_RXDATA, `QSF_STATUS, `QSF_SECOND_CONF:
        mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic tpush;
    logic tpop;
    logic rpush;
    logic rpop;
    logic run;
    logic [7:0] inb;
    tpush = 1'b0;
    tpop = 1'b0;
    rpush = 1'b0;
    rpop = 1'b0;
    run = 1'b0;
    inb = 8'h00;
    next_s = s;
    next_s.s1 = serial_io_i;
    next_s.s2 = s.s1;

    // Read data is latched in the setup cycle so it comes from a flop
    if (apb_setup)
    begin
      case (paddr)
        `QSF_CONF: next_s.rdata = {25'h0, s.stop, (s.ph != PH_IDLE),
          s.pack, s.wr, s.al, s.dl};
        `QSF_OPCODE: next_s.rdata = {16'h0, s.op};
        `QSF_LOCATION: next_s.rdata = s.loc;
        `QSF_READ_MODE: next_s.rdata = {16'h0, s.rm};
        `QSF_HEADER: next_s.rdata = {23'h0, s.hdr};
        `QSF_RXCOUNT: next_s.rdata = {16'h0, s.rxcnt};
        `QSF_RXDATA: next_s.rdata = rempty ? 32'h0 : s.rxm[s.rrp];
        `QSF_STATUS: next_s.rdata = {25'h0, (s.ph != PH_IDLE), s.rudf,
          rfull, rempty, s.tovf, tfull, tempty};
        `QSF_SECOND_CONF: next_s.rdata = {30'h0, s.dma};
        default: next_s.rdata = 32'h0;
      endcase
    end

    // Register writes; the conf lane, write and pack fields are held while a frame runs
    if (apb_wr)
    begin
      case (paddr)
        `QSF_CONF:
        begin
          if (s.ph == PH_IDLE)
          begin
            next_s.dl = pwdata[`QSF_C_LANES+:2];
            next_s.al = pwdata[`QSF_C_ALANE];
            next_s.wr = pwdata[`QSF_C_WRITE];
            next_s.pack = pwdata[`QSF_C_PACK];
          end
          if (pwdata[`QSF_C_STOP] && s.ph != PH_IDLE)
            next_s.stop = 1'b1;
        end
        `QSF_OPCODE: next_s.op = pwdata[15:0];
        `QSF_LOCATION: next_s.loc = pwdata;
        `QSF_READ_MODE: next_s.rm = pwdata[15:0];
        `QSF_HEADER: next_s.hdr = pwdata[8:0];
        `QSF_RXCOUNT: next_s.rxcnt = pwdata[15:0];
        `QSF_TXDATA:
        begin
          if (tfull)
            next_s.tovf = 1'b1;
          else
          begin
            next_s.txm[s.twp] = pwdata;
            tpush = 1'b1;
          end
        end
        `QSF_STATUS:
        begin
          if (pwdata[`QSF_S_TXO])
            next_s.tovf = 1'b0;
          if (pwdata[`QSF_S_RXU])
            next_s.rudf = 1'b0;
        end
        `QSF_SECOND_CONF: next_s.dma = pwdata[1:0];
        default: ;
      endcase
    end

    // Receive port pop; an empty read only flags underflow
    if (apb_rd && paddr == `QSF_RXDATA)
    begin
      if (rempty)
        next_s.rudf = 1'b1;
      else
        rpop = 1'b1;
    end

    // Start a frame at the command phase with select low
    if (apb_wr && paddr == `QSF_CONF && pwdata[`QSF_C_START] &&
      s.ph == PH_IDLE)
    begin
      next_s.dl = pwdata[`QSF_C_LANES+:2];
      next_s.al = pwdata[`QSF_C_ALANE];
      next_s.wr = pwdata[`QSF_C_WRITE];
      next_s.pack = pwdata[`QSF_C_PACK];
      next_s.ph = PH_CMD;
      next_s.left = {1'b0, s.hdr[`QSF_H_CMD+:2]};
      next_s.ss_n = 1'b0;
      next_s.rcnt = s.rxcnt;
      next_s.bsel = 2'd0;
      next_s.acc = 32'h0;
      next_s.stop = 1'b0;
      next_s.nb = 4'd0;
      next_s.rxb = 1'b0;
    end
    else if (s.ph != PH_IDLE && s.nb != 4'd0)
      run = 1'b1;
    else if (s.ph != PH_IDLE)
    begin
      // Byte boundary: store, load the next byte or move on
      if (s.left == 3'd0 && s.ph != PH_DATA)
      begin
        case (s.ph)
          PH_CMD:
          begin
            next_s.ph = PH_ADDR;
            next_s.left = s.hdr[`QSF_H_ADDR+:3];
          end
          PH_ADDR:
          begin
            next_s.ph = PH_MODE;
            next_s.left = s.wr ? 3'd0 : {1'b0, s.hdr[`QSF_H_RM+:2]};
          end
          PH_MODE:
          begin
            next_s.ph = PH_DUMMY;
            next_s.left = {1'b0, s.hdr[`QSF_H_DUMMY+:2]};
          end
          default: next_s.ph = PH_DATA;
        endcase
      end
      else if (s.ph != PH_DATA)
      begin
        next_s.left = s.left - 3'd1;
        next_s.nb = 4'd8;
        next_s.rxb = 1'b0;
        case (s.ph)
          PH_CMD:
          begin
            next_s.sh = pick({16'h0, s.op}, s.left);
            next_s.lanes = 3'd1;
          end
          PH_ADDR:
          begin
            next_s.sh = pick(s.loc, s.left);
            next_s.lanes = s.al ? lane_bits(s.dl) : 3'd1;
          end
          PH_MODE:
          begin
            next_s.sh = pick({16'h0, s.rm}, s.left);
            next_s.lanes = s.al ? lane_bits(s.dl) : 3'd1;
          end
          default:
          begin
            next_s.sh = 8'h00;
            next_s.lanes = s.al ? lane_bits(s.dl) : 3'd1;
          end
        endcase
      end
      else if (s.wr)
      begin
        // Write data: wait on an empty queue, end on stop
        if (s.stop)
        begin
          next_s.ph = PH_IDLE;
          next_s.ss_n = 1'b1;
          next_s.stop = 1'b0;
        end
        else if (!tempty)
        begin
          next_s.sh = s.txm[s.trp][8*s.bsel+:8];
          next_s.nb = 4'd8;
          next_s.lanes = lane_bits(s.dl);
          if (!s.pack || s.bsel == 2'd3)
          begin
            tpop = 1'b1;
            next_s.bsel = 2'd0;
          end
          else
            next_s.bsel = s.bsel + 2'd1;
        end
      end
      else if (s.rxb)
      begin
        // Store the byte just taken in; push when the word is whole
        next_s.rxb = 1'b0;
        next_s.acc[8*s.bsel+:8] = s.sh;
        if (!s.pack || s.bsel == 2'd3)
        begin
          next_s.rxm[s.rwp] = s.pack ? {s.sh, s.acc[23:0]} :
            {24'h0, s.sh};
          rpush = 1'b1;
          next_s.bsel = 2'd0;
          next_s.acc = 32'h0;
        end
        else
          next_s.bsel = s.bsel + 2'd1;
      end
      else if (s.rcnt == 16'd0)
      begin
        // Last byte taken; a partly filled word is still delivered
        if (s.bsel == 2'd0 || !rfull)
        begin
          if (s.bsel != 2'd0)
          begin
            next_s.rxm[s.rwp] = s.acc;
            rpush = 1'b1;
          end
          next_s.ph = PH_IDLE;
          next_s.ss_n = 1'b1;
          next_s.bsel = 2'd0;
        end
      end
      else if (!rfull)
      begin
        next_s.rcnt = s.rcnt - 16'd1;
        next_s.nb = 4'd8;
        next_s.rxb = 1'b1;
        next_s.lanes = lane_bits(s.dl);
      end
    end

    // Bit engine: data set while the clock is low, taken at its fall
    if (run)
    begin
      next_s.div = s.div + 8'd1;
      if (s.div == 8'(SCK_HALF - 1))
      begin
        next_s.div = 8'd0;
        next_s.sck = !s.sck;
        if (s.sck)
        begin
          case (s.lanes)
            3'd4: inb = {s.sh[3:0], io_sync};
            3'd2: inb = {s.sh[5:0], io_sync[1:0]};
            default: inb = {s.sh[6:0], io_sync[1]};
          endcase
          next_s.sh = inb;
          next_s.nb = s.nb - {1'b0, s.lanes};
        end
      end
    end
    else
    begin
      next_s.div = 8'd0;
      next_s.sck = 1'b0;
    end

    // Queue pointers and counts
    if (tpush)
      next_s.twp = s.twp + 1'b1;
    if (tpop)
      next_s.trp = s.trp + 1'b1;
    if (rpush)
      next_s.rwp = s.rwp + 1'b1;
    if (rpop)
      next_s.rrp = s.rrp + 1'b1;
    next_s.tcnt = s.tcnt + {{AW{1'b0}}, tpush} - {{AW{1'b0}}, tpop};
    next_s.rcn = s.rcn + {{AW{1'b0}}, rpush} - {{AW{1'b0}}, rpop};

    // Pin drive follows the shift register; inputs are never driven
    next_s.io_o = 4'h0;
    next_s.io_oe = 4'h0;
    if (next_s.ph != PH_IDLE && !(next_s.ph == PH_DATA && !next_s.wr))
    begin
      case (next_s.lanes)
        3'd4:
        begin
          next_s.io_o = next_s.sh[7:4];
          next_s.io_oe = 4'hf;
        end
        3'd2:
        begin
          next_s.io_o = {2'b00, next_s.sh[7:6]};
          next_s.io_oe = 4'h3;
        end
        default:
        begin
          next_s.io_o = {3'b000, next_s.sh[7]};
          next_s.io_oe = 4'h1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s <= '0;
      s.ph <= PH_IDLE;
      s.ss_n <= 1'b1;
      s.lanes <= 3'd1;
      s.hdr <= `QSF_RST_HDR;
      s.rxcnt <= `QSF_RST_RXCNT;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Zero wait states keep the slave simple; errors only for holes
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = s.rdata;
  assign pins.serial_clock = s.sck;
  assign pins.slave_select_n = s.ss_n;
  assign pins.serial_io_o = s.io_o;
  assign pins.serial_io_oe = s.io_oe;
  // Queue conditions for the system interrupt logic
  assign events.tx_queue_empty_flag = tempty;
  assign events.tx_queue_full_flag = tfull;
  assign events.tx_queue_overflow_flag = s.tovf;
  assign events.rx_queue_empty_flag = rempty;
  assign events.rx_queue_full_flag = rfull;
  assign events.rx_queue_underflow_flag = s.rudf;
  // DMA asks for room or data; requests drop as soon as the queue answers
  assign events.tx_dma_req = s.dma[`QSF_D_TX] && !tfull;
  assign events.rx_dma_req = s.dma[`QSF_D_RX] && !rempty;
endmodule

// ### testbench/flash_model.sv
// Behavioural serial flash facing the master's pins.
// Assumes the bench resolves the data lines and sets the read lane count.
`timescale 1ns/1ns
module flash_model
  import qsf_pkg::*;
(
  // Clock and master pins
  input wire logic clk,
  input wire pins_out_t pins,
  input wire logic [2:0] lanes,
  // Slave drive onto the data lines
  output logic [3:0] io_drive
);
  logic [7:0] rd_q[$];
  logic [7:0] seen_q[$];
  logic prev_sck = 1'b0;
  int bits = 0;

  // Lines for one bit time of read data; bit 7 goes out on the top lane
  function automatic logic [3:0] lane_bits(input int n);
    int p;
    int k;
    logic [7:0] b;
    p = n * lanes;
    b = (p / 8 < rd_q.size()) ? rd_q[p / 8] : 8'h00;
    k = 7 - p % 8;
    if (lanes == 3'd1)
      return {2'b00, b[k], 1'b0};
    if (lanes == 3'd2)
      return {2'b00, b[k -: 2]};
    return b[k -: 4];
  endfunction

  // ----------------------------------------------------------------
  // Capture and answer
  // ----------------------------------------------------------------
  // Read data moves on falling clocks so it settles through the
  // master's synchroniser; a released line toggles, never holds.
  initial io_drive = 4'h5;
  always @(posedge clk)
  begin
    prev_sck <= pins.serial_clock;
    if (pins.slave_select_n)
      bits <= 0;
    else if (pins.serial_clock && !prev_sck)
      seen_q.push_back({pins.serial_io_oe, pins.serial_io_o});
    else if (!pins.serial_clock && prev_sck && pins.serial_io_oe == 4'h0)
      bits <= bits + 1;
    if (pins.slave_select_n || pins.serial_io_oe != 4'h0)
      io_drive <= ~io_drive;
    else
      io_drive <= lane_bits(bits);
  end
endmodule

// ### testbench/qsf_properties.sv
// Assertions on the ports of the serial flash master.
// Assumes the master alone drives its pins and APB answers.
`timescale 1ns/1ns
`include "qsf_regs.svh"
module qsf_properties
  import qsf_pkg::*;
#(
  parameter int SCK_HALF = 4
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Serial side and conditions
  input wire logic [3:0] serial_io_i,
  input wire pins_out_t pins,
  input wire events_t events
);
  int hi_cnt;
  logic acc;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Length of the current high half of the serial clock
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      hi_cnt <= 0;
    else
      hi_cnt <= pins.serial_clock ? hi_cnt + 1 : 0;
  assign acc = psel && penable;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_sck_in_frame: assert property (pins.serial_clock |-> !pins.slave_select_n)
    else $error("serial clock outside a frame");
  chk_drive_in_frame: assert property (|pins.serial_io_oe |-> !pins.slave_select_n)
    else $error("data driven outside a frame");
  chk_sck_high_len: assert property ($fell(pins.serial_clock) |-> hi_cnt == SCK_HALF)
    else $error("serial clock high time wrong");
  chk_io_steady: assert property (pins.serial_clock |-> $stable(pins.serial_io_o))
    else $error("data moved while clock high");
  chk_tx_overflow: assert property (acc && pwrite && paddr == `QSF_TXDATA
    && events.tx_queue_full_flag |=> events.tx_queue_overflow_flag)
    else $error("full write did not flag overflow");
  chk_rx_underflow: assert property (acc && !pwrite && paddr == `QSF_RXDATA
    && events.rx_queue_empty_flag |=> events.rx_queue_underflow_flag)
    else $error("empty read did not flag underflow");
  chk_tx_push: assert property (acc && pwrite && paddr == `QSF_TXDATA
    && events.tx_queue_empty_flag |=> !events.tx_queue_empty_flag)
    else $error("transmit word not queued");
  chk_start_frame: assert property (acc && pwrite && paddr == `QSF_CONF
    && pwdata[`QSF_C_START] && pins.slave_select_n |=> !pins.slave_select_n)
    else $error("start did not open a frame");
  chk_frame_end: assert property ($rose(pins.slave_select_n)
    |-> pins.serial_io_oe == 4'h0 && !pins.serial_clock)
    else $error("frame closed with lines active");
  // Main scenarios reached
  cov_frame: cover property ($fell(pins.slave_select_n));
  cov_rx_full: cover property (events.rx_queue_full_flag && !pins.slave_select_n);
  cov_overflow: cover property ($rose(events.tx_queue_overflow_flag));
endmodule
bind quad_serial_flash_master qsf_properties #(.SCK_HALF(SCK_HALF)) u_qsf_properties (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_io_i(serial_io_i), .pins(pins), .events(events));

// ### testbench/tb.sv
// Self-checking bench for the serial flash master over APB.
// Assumes the flash model answers reads on the lanes set here.
`timescale 1ns/1ns
`include "qsf_regs.svh"
module tb;
  import qsf_pkg::*;
  logic clk = 0;
  logic rst_b = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic [31:0] seed = 32'habe3ea21;
  logic pready;
  logic pslverr;
  logic bad;
  logic [3:0] serial_io_i;
  logic [3:0] io_drive;
  logic [2:0] lanes = 3'd1;
  pins_out_t pins;
  events_t events;
  logic [7:0] exp_q[$];
  logic [31:0] txm[$];
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #4 clk = ~clk;
  // Each line carries the master where it drives, else the flash
  assign serial_io_i = (pins.serial_io_oe & pins.serial_io_o) | (~pins.serial_io_oe & io_drive);
  // Half period of 5 clocks gives the 80 ns serial clock the bench runs at
  quad_serial_flash_master #(.SCK_HALF(5)) u_quad_serial_flash_master (.clk(clk),
    .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_io_i(serial_io_i),
    .pins(pins), .events(events));
  flash_model u_flash_model (.clk(clk), .pins(pins), .lanes(lanes), .io_drive(io_drive));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task close_out;
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // A hang counts as a failure
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_total++;
      close_out;
    end
  end
  function logic [31:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    bad = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Expected lines of one byte, top lane first; upper nibble is the drive mask
  task add_byte(input logic [7:0] b, input int l);
    for (int t = 0; t < 8 / l; t++)
      exp_q.push_back(l == 1 ? {7'h08, b[7 - t]} : l == 2 ? {6'h0c, b[7 - 2 * t -: 2]} :
        {4'hf, b[7 - 4 * t -: 4]});
  endtask
  task push_tx;
    logic [31:0] w;
    w = rnd();
    if (txm.size() < 8)
      txm.push_back(w);
    apb(1, `QSF_TXDATA, w);
  endtask
  task settle(input int n);
    while (u_flash_model.seen_q.size() < n)
      @(posedge clk);
    repeat (100) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // One frame: cf is the low conf fields, hc the header counts
  // ----------------------------------------------------------------
  task frame(input logic [4:0] cf, input logic [8:0] hc, input int pre, input int post,
    input int nrx);
    int la, ld, k, pk;
    logic [31:0] op, ad, rm, w;
    logic [7:0] b;
    ld = cf[1:0] == 2'd1 ? 2 : cf[1:0] == 2'd2 ? 4 : 1;
    la = cf[2] ? ld : 1;
    pk = cf[4] ? 4 : 1;
    op = rnd();
    ad = rnd();
    rm = rnd();
    apb(1, `QSF_OPCODE, op);
    apb(1, `QSF_LOCATION, ad);
    apb(1, `QSF_READ_MODE, rm);
    apb(1, `QSF_HEADER, {23'h0, hc});
    apb(1, `QSF_RXCOUNT, nrx);
    exp_q = {};
    txm = {};
    u_flash_model.seen_q = {};
    u_flash_model.rd_q = {};
    lanes = ld[2:0];
    if (hc[1:0] == 2) add_byte(op[15:8], 1);
    if (hc[1:0] != 0) add_byte(op[7:0], 1);
    for (int i = hc[4:2]; i > 0; i--) add_byte(ad[8 * i - 1 -: 8], la);
    if (!cf[3] && hc[6:5] == 2) add_byte(rm[15:8], la);
    if (!cf[3] && hc[6:5] != 0) add_byte(rm[7:0], la);
    repeat (hc[8:7]) add_byte(8'h00, la);
    repeat (pre) push_tx;
    if (pre > 8)
    begin
      apb(0, `QSF_STATUS, 0);
      check(r[2:1], 2'b11);
      apb(1, `QSF_STATUS, 32'h4);
      apb(0, `QSF_STATUS, 0);
      check(r[2], 1'b0);
    end
    for (int i = 0; i < nrx; i++)
    begin
      b = rnd();
      u_flash_model.rd_q.push_back(b);
    end
    apb(1, `QSF_CONF, {26'h0, 1'b1, cf});
    if (cf[3])
    begin
      for (int j = 0; j < txm.size(); j++)
        for (int q = 0; q < pk; q++) add_byte(txm[j][8 * q +: 8], ld);
      settle(exp_q.size());
      check(u_flash_model.seen_q.size(), exp_q.size());
      k = txm.size();
      repeat (post) push_tx;
      for (int j = k; j < txm.size(); j++)
        for (int q = 0; q < pk; q++) add_byte(txm[j][8 * q +: 8], ld);
      settle(exp_q.size());
      apb(1, `QSF_CONF, 32'h40);
    end
    else
    begin
      repeat (nrx * 8 / ld) exp_q.push_back(8'h00);
      if (pk == 1 && nrx > 8)
      begin
        while (events.rx_queue_full_flag !== 1'b1)
          @(posedge clk);
        k = u_flash_model.seen_q.size();
        repeat (100) @(posedge clk);
        check(u_flash_model.seen_q.size(), k);
      end
      for (int j = 0; j < nrx; j += pk)
      begin
        w = 0;
        for (int q = 0; q < pk && j + q < nrx; q++) w[8 * q +: 8] = u_flash_model.rd_q[j + q];
        do apb(0, `QSF_STATUS, 0); while (r[3] !== 1'b0);
        apb(0, `QSF_RXDATA, 0);
        check(r, w);
      end
    end
    while (pins.slave_select_n !== 1'b1)
      @(posedge clk);
    check(u_flash_model.seen_q.size(), exp_q.size());
    for (int i = 0; i < exp_q.size() && i < u_flash_model.seen_q.size(); i++)
    begin
      b = u_flash_model.seen_q[i];
      check({b[7:4], b[3:0] & b[7:4]}, exp_q[i]);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1;
    apb(0, `QSF_STATUS, 0);
    check(r, 32'h9);
    apb(0, 12'h3f0, 0);
    check({bad, r[30:0]}, 32'h80000000);
    apb(0, `QSF_RXDATA, 0);
    check(r, 32'h0);
    apb(0, `QSF_STATUS, 0);
    check(r[5], 1'b1);
    apb(1, `QSF_STATUS, 32'h20);
    frame(5'b11000, 9'h192, 9, 0, 0);
    frame(5'b01101, 9'h08d, 0, 3, 0);
    frame(5'b11110, 9'h108, 1, 1, 0);
    frame(5'b00001, 9'h00d, 0, 0, 10);
    frame(5'b10101, 9'h0d2, 0, 0, 6);
    frame(5'b10110, 9'h125, 0, 0, 8);
    apb(1, `QSF_SECOND_CONF, 32'h3);
    @(posedge clk);
    check({events.tx_dma_req, events.rx_dma_req}, 2'b10);
    close_out;
  end
endmodule
